// ---- dssq_defines.vh ----
`ifndef DSSQ_DEFINES_VH
`define DSSQ_DEFINES_VH
`define DSSQ_PRESCALE      4
`define DSSQ_INT_COUNTS    1000
`define DSSQ_DE_MAX        2000
`define DSSQ_AZ_MIN        1000
`define DSSQ_CYCLE_COUNTS  4000
`define DSSQ_BP_DIV        800
`define DSSQ_BP_HALF       400
`endif

// ---- dssq_sequencer.v ----
`timescale 1ns/1ns
`default_nettype none
`include "dssq_defines.vh"
module dssq_sequencer
#(
   // phase counters are 12 bits wide, so no count may exceed 4095; the backplane counter is 10 bits
   parameter INT_COUNTS   = `DSSQ_INT_COUNTS,
   parameter DE_MAX       = `DSSQ_DE_MAX,
   parameter CYCLE_COUNTS = `DSSQ_CYCLE_COUNTS,
   parameter BP_HALF      = `DSSQ_BP_HALF
)
(
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        clk_en_in,
   input  wire        comp_in,
   input  wire        hold_reading_input_in,
   input  wire        seg_check_in,
   output reg         sw_autozero_out,
   output reg         sw_integrate_out,
   output reg         reference_deintegrate_phase_out,
   output reg         ref_pos_out,
   output reg         ref_neg_out,
   output reg         in_common_out,
   output reg  [15:0] reading_bcd_out,
   output reg         minus_out,
   output reg         overload_out,
   output reg  [27:0] seg_out,
   output reg         sign_seg_out,
   output reg         backplane_drive_out
);

   ////////////////////////////////////////////////////////////////////////
   // phase codes, one-hot
   localparam [2:0] ST_AZ  = 3'b001;
   localparam [2:0] ST_INT = 3'b010;
   localparam [2:0] ST_DE  = 3'b100;

   reg  [1:0]  pre_ff;
   reg  [2:0]  state_ff;
   reg  [11:0] cnt_ff;
   reg  [11:0] cyc_ff;
   reg         sign_ff;
   reg         done_ff;
   reg  [15:0] de_bcd_ff;
   reg  [9:0]  bp_cnt_ff;
   reg         bp_ff;
   reg  [15:0] lat_bcd_ff;
   reg         lat_minus_ff;
   reg         lat_ovl_ff;

   // one count tick every fourth enabled clock
   wire tick = clk_en_in & (pre_ff == 2'd3);

   ////////////////////////////////////////////////////////////////////////
   // phase end conditions, named so the sequencer reads plainly
   wire cyc_wrap   = (cyc_ff == CYCLE_COUNTS - 1);
   wire int_end    = (cnt_ff == INT_COUNTS - 1);
   wire zero_cross = (comp_in != sign_ff);
   wire de_full    = (cnt_ff == DE_MAX - 1);
   // latch strobe on the first auto-zero tick, before the next cycle
   // can overwrite the de-integrate count
   wire latch_load = tick & (state_ff == ST_AZ) & (cnt_ff == 12'd0);

   ////////////////////////////////////////////////////////////////////////
   // divide-by-four prescaler making the count clock
   // freezes with the clock enable like all other state
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
         pre_ff <= 2'd0;
      else if (clk_en_in)
         pre_ff <= pre_ff + 2'd1;
   end

   ////////////////////////////////////////////////////////////////////////
   // bcd increment of the de-integrate count, ripple per decade
   function [15:0] bcd_inc;
      input [15:0] v;
      reg   [15:0] r;
      reg          c;
      integer      i;
      begin
         r = v;
         c = 1'b1;
         // carry ripples on only while a decade wraps from nine
         for (i = 0; i < 4; i = i + 1)
         begin
            if (c)
            begin
               if (r[i*4 +: 4] == 4'd9)
                  r[i*4 +: 4] = 4'd0;
               else
               begin
                  r[i*4 +: 4] = r[i*4 +: 4] + 4'd1;
                  c = 1'b0;
               end
            end
         end
         bcd_inc = r;
      end
   endfunction

   // seven segment decode, bit order g..a; blank code 4'hf
   function [6:0] seg7;
      input [3:0] d;
      begin
         case (d)
            4'd0:    seg7 = 7'h3f;
            4'd1:    seg7 = 7'h06;
            4'd2:    seg7 = 7'h5b;
            4'd3:    seg7 = 7'h4f;
            4'd4:    seg7 = 7'h66;
            4'd5:    seg7 = 7'h6d;
            4'd6:    seg7 = 7'h7d;
            4'd7:    seg7 = 7'h07;
            4'd8:    seg7 = 7'h7f;
            4'd9:    seg7 = 7'h6f;
            default: seg7 = 7'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // phase sequencer; cycle counter fixes total length so auto-zero absorbs
   // whatever de-integrate left unused
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         state_ff  <= ST_AZ;
         cnt_ff    <= 12'd0;
         cyc_ff    <= 12'd0;
         sign_ff   <= 1'b0;
         done_ff   <= 1'b0;
         de_bcd_ff <= 16'h0000;
      end
      else if (tick)
      begin
         cnt_ff <= cnt_ff + 12'd1;
         if (cyc_wrap)
            cyc_ff <= 12'd0;
         else
            cyc_ff <= cyc_ff + 12'd1;
         case (state_ff)
            ST_AZ:
            begin
               // auto-zero ends at cycle wrap, 1000..2999 counts long (4000 after reset)
               if (cyc_wrap)
               begin
                  state_ff <= ST_INT;
                  cnt_ff   <= 12'd0;
               end
            end
            ST_INT:
            begin
               // sign sampled once, at the last integrate tick
               if (int_end)
               begin
                  state_ff  <= ST_DE;
                  sign_ff   <= comp_in;
                  cnt_ff    <= 12'd0;
                  done_ff   <= 1'b0;
                  de_bcd_ff <= 16'h0000;
               end
            end
            ST_DE:
            begin
               // comparator flips when integrator crosses zero
               // reading counts ticks before the crossing, not the crossing
               if (zero_cross || de_full)
               begin
                  state_ff <= ST_AZ;
                  // count restarts so the latch strobe sees zero
                  cnt_ff   <= 12'd0;
                  done_ff  <= zero_cross;
               end
               else
                  de_bcd_ff <= bcd_inc(de_bcd_ff);
            end
            default:
            begin
               // illegal one-hot code: recover into auto-zero
               state_ff <= ST_AZ;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result latch; conversions run on regardless of hold
   // hold freezes only the transfer, the sequencer above never stops
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         lat_bcd_ff   <= 16'h0000;
         lat_minus_ff <= 1'b0;
         lat_ovl_ff   <= 1'b0;
      end
      else if (latch_load && !hold_reading_input_in)
      begin
         lat_bcd_ff   <= de_bcd_ff;
         lat_minus_ff <= sign_ff;
         lat_ovl_ff   <= ~done_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // backplane: toggle every 400 oscillator cycles, period 800
   // free-running, independent of the conversion phases
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         bp_cnt_ff <= 10'd0;
         bp_ff     <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (bp_cnt_ff == BP_HALF - 1)
         begin
            bp_cnt_ff <= 10'd0;
            bp_ff     <= ~bp_ff;
         end
         else
            bp_cnt_ff <= bp_cnt_ff + 10'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // display and analog switch outputs, all registered
   reg  [27:0] nxt_on;
   reg         nxt_sign_on;
   // per-digit decode of the latched reading
   wire [6:0]  units_seg = seg7(lat_bcd_ff[3:0]);
   wire [6:0]  tens_seg  = seg7(lat_bcd_ff[7:4]);
   wire [6:0]  hund_seg  = seg7(lat_bcd_ff[11:8]);
   always @*
   begin
      nxt_on[6:0]   = lat_ovl_ff ? 7'h00 : units_seg;
      nxt_on[13:7]  = lat_ovl_ff ? 7'h00 : tens_seg;
      nxt_on[20:14] = lat_ovl_ff ? 7'h00 : hund_seg;
      // thousands digit shows only a one (segments b,c)
      nxt_on[27:21] = (lat_ovl_ff | lat_bcd_ff[12]) ? 7'h06 : 7'h00;
      // minus segment follows the latched sign
      nxt_sign_on   = lat_minus_ff;
      // segment check overrides overload blanking
      if (seg_check_in)
      begin
         nxt_on      = {7'h06, 7'h7f, 7'h7f, 7'h7f};
         nxt_sign_on = 1'b1;
      end
   end

   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         sw_autozero_out                 <= 1'b0;
         sw_integrate_out                <= 1'b0;
         reference_deintegrate_phase_out <= 1'b0;
         ref_pos_out                     <= 1'b0;
         ref_neg_out                     <= 1'b0;
         in_common_out                   <= 1'b0;
         reading_bcd_out                 <= 16'h0000;
         minus_out                       <= 1'b0;
         overload_out                    <= 1'b0;
         seg_out                         <= 28'h0000000;
         sign_seg_out                    <= 1'b0;
         backplane_drive_out             <= 1'b0;
      end
      else if (clk_en_in)
      begin
         // phase switches to the integrator front end
         sw_autozero_out  <= state_ff[0];
         sw_integrate_out <= state_ff[1];
         reference_deintegrate_phase_out <= state_ff[2];
         // reference opposes the captured sign to ramp back to zero
         ref_pos_out   <= state_ff[2] & sign_ff;
         ref_neg_out   <= state_ff[2] & ~sign_ff;
         // input shorted to common everywhere but integrate
         in_common_out <= state_ff[0] | state_ff[2];
         // latched result
         reading_bcd_out <= lat_bcd_ff;
         minus_out       <= lat_minus_ff;
         overload_out    <= lat_ovl_ff;
         // display drive
         backplane_drive_out <= bp_ff;
         // steady drive in check mode; can burn a glass if left on
         if (seg_check_in)
         begin
            seg_out      <= nxt_on;
            sign_seg_out <= nxt_sign_on;
         end
         else
         begin
            seg_out      <= {28{bp_ff}} ^ nxt_on;
            sign_seg_out <= bp_ff ^ nxt_sign_on;
         end
      end
   end

endmodule
`default_nettype wire

// ---- dssq_sequencer_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module dssq_sequencer_checker
(
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic        seg_check_in,
   input wire logic        sw_autozero_out,
   input wire logic        sw_integrate_out,
   input wire logic        reference_deintegrate_phase_out,
   input wire logic        in_common_out,
   input wire logic        overload_out,
   input wire logic [27:0] seg_out,
   input wire logic        backplane_drive_out
);
   logic [13:0] int_ff;
   logic [13:0] cyc_ff;
   logic [8:0]  bp_ff;
   logic        int_q_ff;
   logic        bp_q_ff;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   // clock counters; zero means not yet armed, so no check before one lap
   always_ff @(posedge clk_sys_in)
   begin
      int_q_ff <= sw_integrate_out;
      bp_q_ff  <= backplane_drive_out;
      int_ff   <= sw_integrate_out ? int_ff + 14'h1 : 14'h0;
      if (!rst_n_in)
      begin
         cyc_ff <= 14'h0;
         bp_ff  <= 9'h0;
      end
      else
      begin
         cyc_ff <= (sw_integrate_out && !int_q_ff) ? 14'h1
                 : (cyc_ff != 14'h0) ? cyc_ff + 14'h1 : 14'h0;
         bp_ff  <= (backplane_drive_out != bp_q_ff) ? 9'h1
                 : (bp_ff != 9'h0) ? bp_ff + 9'h1 : 9'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_int_entry: assert property (
      $rose(sw_integrate_out) |-> $past(sw_autozero_out))
      else $error("bad integrate entry");
   a_de_entry: assert property (
      $rose(reference_deintegrate_phase_out) |-> $past(sw_integrate_out))
      else $error("bad deintegrate entry");
   a_int_length: assert property (
      $fell(sw_integrate_out) |-> int_ff == 14'hfa0)
      else $error("bad integrate length");
   a_cycle_len: assert property (
      sw_integrate_out && !int_q_ff && cyc_ff != 14'h0 |-> cyc_ff == 14'h3e80)
      else $error("bad cycle length");
   a_common_sel: assert property (
      in_common_out == (sw_autozero_out || reference_deintegrate_phase_out))
      else $error("bad common select");
   a_bp_period: assert property (
      backplane_drive_out != bp_q_ff && bp_ff != 9'h0 |-> bp_ff == 9'h190)
      else $error("bad backplane period");
   a_check_steady: assert property (
      (seg_check_in && rst_n_in)[*3] |-> $stable(seg_out))
      else $error("segments move in check");
   a_ovl_blank: assert property (
      !seg_check_in && !$past(seg_check_in) && overload_out
         |-> seg_out[20:0] == {21{backplane_drive_out}})
      else $error("overload not blanked");
endmodule
bind dssq_sequencer dssq_sequencer_checker u_dssq_sequencer_checker
(
   .clk_sys_in, .rst_n_in, .seg_check_in, .sw_autozero_out,
   .sw_integrate_out, .reference_deintegrate_phase_out, .in_common_out,
   .overload_out, .seg_out, .backplane_drive_out
);
`default_nettype wire

// ---- dssq_frontend_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dssq_frontend_model
(
   input  wire logic        clk_sys_in,
   input  wire logic        deint_in,
   input  wire logic [11:0] count_in,
   input  wire logic        sign_in,
   output wire logic        comp_out
);
   logic [13:0] t_ff = 14'h0;
   logic        comp_ff = 1'b0;
   assign comp_out = comp_ff;
   // ramp crosses zero mid-tick after count_in ticks, never if too large
   always_ff @(posedge clk_sys_in)
   begin
      t_ff    <= deint_in ? t_ff + 14'h1 : 14'h0;
      comp_ff <= (deint_in && t_ff >= 4 * count_in) ? ~sign_in : sign_in;
   end
endmodule
`default_nettype wire

// ---- dssq_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module dssq_sequencer_tb;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        hold_reading_input_in = 1'b0;
   logic        seg_check_in = 1'b0;
   logic        comp_in;
   logic [11:0] n_val = 12'h0;
   logic        sign_val = 1'b0;
   logic        sw_autozero_out;
   logic        sw_integrate_out;
   logic        reference_deintegrate_phase_out;
   logic        ref_pos_out;
   logic        ref_neg_out;
   logic [15:0] reading_bcd_out;
   logic        minus_out;
   logic        overload_out;
   logic [27:0] seg_out;
   logic        sign_seg_out;
   logic        backplane_drive_out;
   int          error_cnt = 0;
   int          samples_checked = 0;
   always #50 clk_sys_in = ~clk_sys_in;
   dssq_sequencer u_dssq_sequencer
   (
      .clk_sys_in, .rst_n_in, .clk_en_in(1'b1), .comp_in,
      .hold_reading_input_in, .seg_check_in, .sw_autozero_out,
      .sw_integrate_out, .reference_deintegrate_phase_out, .ref_pos_out,
      .ref_neg_out, .in_common_out(), .reading_bcd_out, .minus_out,
      .overload_out, .seg_out, .sign_seg_out, .backplane_drive_out
   );
   dssq_frontend_model u_dssq_frontend_model
   (
      .clk_sys_in, .deint_in(reference_deintegrate_phase_out),
      .count_in(n_val), .sign_in(sign_val), .comp_out(comp_in)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // inputs move just after the edge so no race with the design
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // bounded wait for a phase output: 0 offset, 1 integrate, 2 deintegrate
   task automatic wait_ph(input int k);
      logic [2:0] ph;
      for (int i = 0; i < 20000; i++)
      begin
         ph = {reference_deintegrate_phase_out, sw_integrate_out,
               sw_autozero_out};
         if (ph[k] === 1'b1)
            return;
         cyc(1);
      end
      error_cnt++;
      tally_and_finish();
   endtask
   task automatic conv(input logic [11:0] n, input logic s);
      n_val = n;
      sign_val = s;
      wait_ph(1);
      wait_ph(2);
      cyc(2);
      chk(ref_pos_out === s && ref_neg_out === !s, "ref polarity");
      wait_ph(0);
      cyc(4);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_positive();
      conv(12'd123, 1'b0);
      chk(reading_bcd_out === 16'h0123 && minus_out === 1'b0, "rd");
   endtask
   task automatic t_hold();
      hold_reading_input_in = 1'b1;
      conv(12'd456, 1'b1);
      chk(reading_bcd_out === 16'h0123 && minus_out === 1'b0, "hd");
      hold_reading_input_in = 1'b0;
   endtask
   task automatic t_negative();
      conv(12'd1000, 1'b1);
      chk(reading_bcd_out === 16'h1000 && minus_out === 1'b1, "ng");
      chk((seg_out ^ {28{backplane_drive_out}}) ===
          {7'h06, 7'h3f, 7'h3f, 7'h3f} && sign_seg_out === ~backplane_drive_out,
          "segment phase");
   endtask
   task automatic t_overload();
      conv(12'd2500, 1'b0);
      chk(overload_out === 1'b1 && reading_bcd_out[15:12] === 4'h1, "ov");
   endtask
   task automatic t_segcheck();
      logic [27:0] s0;
      seg_check_in = 1'b1;
      cyc(3);
      s0 = seg_out;
      chk(seg_out[20:0] === {21{s0[0]}} && sign_seg_out === s0[0] &&
          seg_out[23:22] === {2{s0[0]}} && seg_out[21] !== s0[0], "all on");
      cyc(900);
      chk(seg_out === s0, "check not steady");
      seg_check_in = 1'b0;
   endtask
   initial
   begin
      cyc(12);
      rst_n_in = 1'b1;
      t_positive();
      t_hold();
      t_negative();
      t_overload();
      t_segcheck();
      tally_and_finish();
   end
endmodule
`default_nettype wire
